//--- dv/ard_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// serial host: clock stands still low outside frames
module ard_host_model (
  // link
  output logic sclk,
  output logic sync_n,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    din = 1'b1;
  end

  // msb first, strobe low for the whole frame; short n aborts early
  task automatic frame(input logic [15:0] w, input int n,
                       output logic [15:0] rd);
    rd = 16'h0000;
    #7 sync_n = 1'b0;
    #20;
    for (int i = 15; i > 15 - n; i--) begin
      din = w[i];
      #15 rd[i] = dout;
      sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    #10 sync_n = 1'b1;
    // released line: no pull, so show the inverse of the last bit
    din = ~din;
  endtask
endmodule
`default_nettype wire

//--- dv/ard_register_access_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// port checker
module ard_register_access_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // watched ports
  input wire logic sync_n,
  input wire logic din_oe,
  input wire logic iface_variant_sel,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic cal_done,
  input wire logic cal_start,
  input wire logic cal_busy,
  input wire logic input_config_sel,
  input wire logic neg_is_ground,
  input wire logic [2:0] pos_input,
  input wire logic [2:0] neg_input
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_conv_one_pulse: assert property (conv_start |=> !conv_start)
    else $error("conv start longer than one cycle");
  chk_conv_busy_set: assert property (conv_start |-> conv_busy)
    else $error("busy not set with conv start");
  chk_conv_busy_clr: assert property (conv_done && conv_busy && !conv_start
    |=> !conv_busy)
    else $error("conv busy not cleared");
  chk_cal_start_pulse: assert property (cal_start |-> cal_busy ##1 !cal_start)
    else $error("cal start pulse wrong");
  chk_cal_busy_clr: assert property (cal_done && cal_busy && !cal_start
    |=> !cal_busy)
    else $error("cal busy not cleared");
  chk_ground_follow: assert property (neg_is_ground == input_config_sel)
    else $error("ground flag differs from config");
  chk_diff_pairing: assert property (!input_config_sel |->
    pos_input[2:1] == neg_input[2:1] && pos_input[0] != neg_input[0])
    else $error("differential pair wrong");
  chk_oe_variant: assert property (din_oe |-> !sync_n && iface_variant_sel)
    else $error("data pin driven outside variant");
endmodule

bind ard_register_access ard_register_access_chk i_chk (.clk(clk),
  .nrst(nrst), .sync_n(sync_n), .din_oe(din_oe),
  .iface_variant_sel(iface_variant_sel), .conv_done(conv_done),
  .conv_start(conv_start), .conv_busy(conv_busy), .cal_done(cal_done),
  .cal_start(cal_start), .cal_busy(cal_busy),
  .input_config_sel(input_config_sel), .neg_is_ground(neg_is_ground),
  .pos_input(pos_input), .neg_input(neg_input));
`default_nettype wire

//--- dv/ard_register_access_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// testbench
module ard_register_access_tb;
  import ard_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, conv_done = 1'b0, cal_done = 1'b0;
  logic sleep_n = 1'b1;
  logic [11:0] conv_result = 12'h000;
  logic sclk, sync_n, hdin, din_out, din_oe, dout, conv_start, conv_busy;
  logic cal_start, cal_busy, cal_system, input_config_sel, neg_is_ground;
  logic sleep_req, iface_variant_sel;
  logic [1:0] cal_kind, power_down_sel;
  logic [2:0] pos_input, neg_input;
  logic [15:0] rd;
  wire din_w;
  int fails = 0, cmp_count = 0;

  // device wins the shared data wire while it enables its driver
  assign din_w = din_oe ? din_out : hdin;
  always #50 clk = ~clk;

  ard_register_access i_dut (.*, .din_in(din_w));
  ard_host_model i_host (.sclk(sclk), .sync_n(sync_n), .din(hdin),
    .dout(dout));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // 12 cycles covers the 3..5 cycle update and the frame spacing
  task xf(input logic [15:0] w, input int n = 16);
    @(posedge clk);
    i_host.frame(w, n, rd);
    repeat (12) @(posedge clk);
  endtask

  task done_pulse(input bit cal);
    @(posedge clk);
    conv_done <= !cal;
    cal_done <= cal;
    @(posedge clk);
    conv_done <= 1'b0;
    cal_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task finish_test;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({7'h00, din_oe, conv_busy, cal_busy, input_config_sel,
      iface_variant_sel,
      cal_kind, power_down_sel}, 16'h0000);
    conv_result <= 12'hABC;
    done_pulse(1'b0);
    xf(16'h3FFF);
    chk(rd, 16'h0ABC);
    chk({15'h0000, input_config_sel}, 16'h0000);
    xf(16'h6A5C);
    xf({2'b11, 14'h0040});
    xf(16'h0000);
    chk(rd, 16'h2A5C);
    xf(16'hFFFF, 10);
    xf(16'h0000);
    chk(rd, 16'h2A5C);
    xf({2'b11, 14'h0084});
    xf({2'b10, 14'h1234});
    xf(16'h0000);
    chk(rd, 16'h1234);
    xf({2'b11, 14'h0082});
    xf(16'h0000);
    chk(rd, 16'h0000);
    xf({2'b11, 14'h3FC8});
    chk({6'h00, input_config_sel, neg_is_ground, pos_input, power_down_sel,
      cal_system, cal_kind}, 16'h03FC);
    xf(16'h0000);
    chk(rd, 16'h3FC8);
    for (int c = 0; c < 8; c++) begin
      xf({2'b11, 1'b0, c[2:0], 10'h000});
      chk({10'h000, pos_input, neg_input},
        {10'h000, c[1:0], c[2], c[1:0], ~c[2]});
    end
    xf({2'b11, 14'h0010});
    chk({15'h0000, conv_busy}, 16'h0001);
    conv_result <= 12'h123;
    done_pulse(1'b0);
    chk({15'h0000, conv_busy}, 16'h0000);
    xf(16'h0000);
    chk(rd, 16'h0123);
    xf({2'b11, 14'h000D});
    chk({12'h000, cal_busy, cal_system, cal_kind}, 16'h000E);
    done_pulse(1'b1);
    chk({15'h0000, cal_busy}, 16'h0000);
    xf({2'b11, 14'h0020});
    chk({15'h0000, iface_variant_sel}, 16'h0001);
    xf(16'h0000);
    chk({15'h0000, iface_variant_sel}, 16'h0000);
    @(posedge clk);
    sleep_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk({15'h0000, sleep_req}, 16'h0001);
    sleep_n <= 1'b1;
    finish_test;
  end
endmodule
`default_nettype wire

//--- hdl/ard_consts.svh
`ifndef ARD_CONSTS_SVH
`define ARD_CONSTS_SVH

// ==========================================================================
// frame format
`define ARD_FRAME_BITS 16
`define ARD_DATA_BITS 14
`define ARD_RESULT_BITS 12
`define ARD_TGT_HI 15
`define ARD_TGT_LO 14

// ==========================================================================
// control word fields and reset value
`define ARD_CTRL_RESET 14'h0000
`define ARD_TEST_RESET 14'h0000
`define ARD_CAL_RESET 14'h0000
`define ARD_BIT_INPUT_CFG 13
`define ARD_BIT_MUX_HI 12
`define ARD_BIT_MUX_LO 10
`define ARD_BIT_PD_HI 9
`define ARD_BIT_PD_LO 8
`define ARD_BIT_RD_HI 7
`define ARD_BIT_RD_LO 6
`define ARD_BIT_IFACE 5
`define ARD_BIT_CONV_GO 4
`define ARD_BIT_TRIM_SRC 3
`define ARD_BIT_TRIM_HI 2
`define ARD_BIT_TRIM_LO 1
`define ARD_BIT_TRIM_GO 0

// ==========================================================================
// status word fields
`define ARD_STAT_BUSY 14
`define ARD_STAT_SPARE 4

`endif

//--- hdl/ard_pkg.sv
`include "ard_consts.svh"

package ard_pkg;

  // ========================================================================
  // enumerations
  typedef enum logic [1:0] {
    TGT_NONE,
    TGT_TEST,
    TGT_CAL,
    TGT_CTRL
  } ard_target_e;

  typedef enum logic [1:0] {
    RD_RESULT,
    RD_TEST,
    RD_CAL,
    RD_STATUS
  } ard_read_src_e;

  // ========================================================================
  // words and state records
  typedef logic [`ARD_DATA_BITS-1:0] ard_data_t;
  typedef logic [`ARD_FRAME_BITS-1:0] ard_word_t;
  typedef ard_data_t [3:0] ard_cal_t;

  typedef struct packed {
    ard_data_t ctrl;
    ard_data_t test;
    ard_cal_t cal;
    logic [`ARD_RESULT_BITS-1:0] result;
    logic [2:0] frame_sync;
    logic frame_seen;
    logic [2:0] sleep_sync;
    logic sleep_level;
    logic conv_busy;
    logic cal_busy;
    logic conv_start;
    logic cal_start;
    ard_word_t rd_word;
  } ard_core_s;

  typedef struct packed {
    ard_word_t shift_in;
    ard_word_t shift_out;
    ard_word_t word;
    logic done_tgl;
  } ard_link_s;

  typedef struct packed {
    logic [4:0] count;
  } ard_frame_s;

endpackage

//--- hdl/ard_register_access.sv
`timescale 1ns/100ps
`default_nettype none
`include "ard_consts.svh"

// What this block does
// - 16-bit frame, top two bits pick target
// - registers change only after full frame
// - target 00 discards the data
// - target 01 writes test register
// - target 10 writes selected calibration register
// - target 11 writes control word
// - control bits 7:6 pick read source
// - read source is result after reset
// - read source holds until control rewritten
// - result reads with four leading zeros
// - control word 14 bits, read back via status, reset zero
// - bit 13 picks differential or single-ended
// - bits 12:10 pick channel, zero is 1/2
// - bits 9:8 with sleep pin pick power-down
// - bit 5 one drives read data on input
// - interface bit cleared after every full frame, unless that frame writes the control word with bit 5 set
// - bit 4 starts conversion, cleared at end
// - bit 3 picks self or system calibration
// - bit 0 starts calibration, cleared at end
// - bit 0 low makes bits 2:1 an index
// - channel codes map to input pairs or ground
// - calibration codes decode to calibration kind
module ard_register_access
  import ard_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial link from the host
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din_in,
  output logic din_out,
  output logic din_oe,
  output logic dout,
  // converter core
  input wire logic conv_done,
  input wire logic [`ARD_RESULT_BITS-1:0] conv_result,
  output logic conv_start,
  output logic conv_busy,
  input wire logic cal_done,
  output logic cal_start,
  output logic cal_busy,
  output logic cal_system,
  output logic [1:0] cal_kind,
  // input multiplexer
  output logic input_config_sel,
  output logic [2:0] pos_input,
  output logic [2:0] neg_input,
  output logic neg_is_ground,
  // power management
  input wire logic sleep_n,
  output logic [1:0] power_down_sel,
  output logic sleep_req,
  // interface variant
  output logic iface_variant_sel
);

  // ========================================================================
  // state
  ard_core_s core;
  ard_core_s next_core;
  ard_link_s link;
  ard_link_s next_link;
  ard_frame_s frame;
  ard_frame_s next_frame;

  logic frame_rst_n;
  logic frame_evt;
  ard_word_t frame_word;
  ard_data_t frame_data;
  ard_target_e frame_target;
  logic [1:0] cal_index;
  ard_read_src_e rd_src;
  ard_word_t status_word;

  // ========================================================================
  // link domain: frame bit counter
  // sclk stops between frames, so the strobe itself clears the counter
  assign frame_rst_n = nrst & ~sync_n;

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  always_comb begin
    next_link = link;
    next_frame = frame;
    // bits past the sixteenth are ignored
    if (frame.count < 5'(`ARD_FRAME_BITS)) begin
      next_link.shift_in = {link.shift_in[`ARD_FRAME_BITS-2:0], din_in};
      // rd_word is quiet during a frame, so one sample is safe
      if (frame.count == 5'h00) begin
        next_link.shift_out = {core.rd_word[`ARD_FRAME_BITS-2:0], 1'b0};
      end else begin
        next_link.shift_out = {link.shift_out[`ARD_FRAME_BITS-2:0], 1'b0};
      end
      next_frame.count = frame.count + 5'h01;
      // word is latched only on the last bit of a whole frame
      if (frame.count == 5'(`ARD_FRAME_BITS - 1)) begin
        next_link.word = {link.shift_in[`ARD_FRAME_BITS-2:0], din_in};
        // toggle, not a level: the strobe would clear a level before clk
        next_link.done_tgl = ~link.done_tgl;
      end
    end
  end

  // ========================================================================
  // read data onto the pins, msb first
  always_comb begin
    if (frame.count == 5'h00) begin
      dout = core.rd_word[`ARD_FRAME_BITS-1];
    end else begin
      dout = link.shift_out[`ARD_FRAME_BITS-1];
    end
  end

  assign din_out = dout;
  // two-wire variant turns the input pin around
  assign din_oe = ~sync_n & core.ctrl[`ARD_BIT_IFACE];

  // ========================================================================
  // system domain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end

  // link.word holds for a whole frame after done, so it is read directly
  assign frame_word = link.word;
  assign frame_data = frame_word[`ARD_DATA_BITS-1:0];
  assign frame_target = ard_target_e'(frame_word[`ARD_TGT_HI:`ARD_TGT_LO]);
  assign cal_index = core.ctrl[`ARD_BIT_TRIM_HI:`ARD_BIT_TRIM_LO];

  always_comb begin
    next_core = core;
    next_core.conv_start = 1'b0;
    next_core.cal_start = 1'b0;

    // done toggle and sleep pin: three flops, stable when 2nd and 3rd agree
    next_core.frame_sync = {core.frame_sync[1:0], link.done_tgl};
    if (core.frame_sync[1] == core.frame_sync[2]) begin
      next_core.frame_seen = core.frame_sync[2];
    end
    next_core.sleep_sync = {core.sleep_sync[1:0], ~sleep_n};
    if (core.sleep_sync[1] == core.sleep_sync[2]) begin
      next_core.sleep_level = core.sleep_sync[2];
    end
    frame_evt = next_core.frame_seen ^ core.frame_seen;

    // end of conversion and calibration clear their go bits first
    if (conv_done) begin
      next_core.ctrl[`ARD_BIT_CONV_GO] = 1'b0;
      next_core.conv_busy = 1'b0;
      next_core.result = conv_result;
    end
    if (cal_done) begin
      next_core.ctrl[`ARD_BIT_TRIM_GO] = 1'b0;
      next_core.cal_busy = 1'b0;
    end

    // a frame write comes after, so a fresh start wins over a done
    if (frame_evt) begin
      // every frame is also a read cycle
      next_core.ctrl[`ARD_BIT_IFACE] = 1'b0;
      unique case (frame_target)
        TGT_NONE: begin
          next_core.ctrl = next_core.ctrl;
        end
        TGT_TEST: begin
          next_core.test = frame_data;
        end
        TGT_CAL: begin
          // coefficients are left alone while a calibration runs
          if (!core.ctrl[`ARD_BIT_TRIM_GO]) begin
            next_core.cal[cal_index] = frame_data;
          end
        end
        TGT_CTRL: begin
          next_core.ctrl = frame_data;
          if (frame_data[`ARD_BIT_CONV_GO]) begin
            next_core.conv_start = 1'b1;
            next_core.conv_busy = 1'b1;
          end
          if (frame_data[`ARD_BIT_TRIM_GO]) begin
            next_core.cal_start = 1'b1;
            next_core.cal_busy = 1'b1;
          end
        end
      endcase
    end

    // read word follows the next state so it is ready for the next frame
    rd_src = ard_read_src_e'(
      next_core.ctrl[`ARD_BIT_RD_HI:`ARD_BIT_RD_LO]);
    status_word = {2'b00, next_core.ctrl};
    status_word[`ARD_STAT_BUSY] = next_core.conv_busy | next_core.cal_busy;
    status_word[`ARD_STAT_SPARE] = 1'b0;
    unique case (rd_src)
      RD_RESULT: begin
        next_core.rd_word = {4'h0, next_core.result};
      end
      RD_TEST: begin
        next_core.rd_word = {2'b00, next_core.test};
      end
      RD_CAL: begin
        next_core.rd_word = {2'b00,
          next_core.cal[next_core.ctrl[`ARD_BIT_TRIM_HI:`ARD_BIT_TRIM_LO]]};
      end
      RD_STATUS: begin
        next_core.rd_word = status_word;
      end
    endcase
  end

  // ========================================================================
  // control word decode to the converter
  // control word is never returned as such; only via status
  assign input_config_sel = core.ctrl[`ARD_BIT_INPUT_CFG];
  // top channel bit swaps pair polarity, low bits pick the pair
  assign pos_input = {core.ctrl[`ARD_BIT_MUX_LO+1:`ARD_BIT_MUX_LO],
    core.ctrl[`ARD_BIT_MUX_HI]};
  assign neg_input = {core.ctrl[`ARD_BIT_MUX_LO+1:`ARD_BIT_MUX_LO],
    ~core.ctrl[`ARD_BIT_MUX_HI]};
  assign neg_is_ground = core.ctrl[`ARD_BIT_INPUT_CFG];
  assign power_down_sel = core.ctrl[`ARD_BIT_PD_HI:`ARD_BIT_PD_LO];
  assign sleep_req = core.sleep_level;
  assign iface_variant_sel = core.ctrl[`ARD_BIT_IFACE];
  assign cal_system = core.ctrl[`ARD_BIT_TRIM_SRC];
  assign cal_kind = core.ctrl[`ARD_BIT_TRIM_HI:`ARD_BIT_TRIM_LO];
  assign conv_start = core.conv_start;
  assign conv_busy = core.conv_busy;
  assign cal_start = core.cal_start;
  assign cal_busy = core.cal_busy;

endmodule
`default_nettype wire
